// *** rtl/abse_regs.svh ***
`ifndef ABSE_REGS_SVH
`define ABSE_REGS_SVH

// ----------------------------------------------------------------
// Opcode patterns
// ----------------------------------------------------------------
`define ABSE_OP_AND_HI   4'h1
`define ABSE_OP_AND_MID  2'h1
`define ABSE_OP_CLR      4'h4
`define ABSE_OP_SET      4'h5

// ----------------------------------------------------------------
// Register file layout and reset values
// ----------------------------------------------------------------
`define ABSE_PORT_LO     5'h05
`define ABSE_PORT_HI     5'h07
`define ABSE_ACC_RST     8'h00
`define ABSE_RF_RST      8'h00
`define ABSE_ZERO_RST    1'h0
`define ABSE_DEST_ACC    1'h0

`endif

// *** rtl/abse_pkg.sv ***
package abse_pkg;

  // ----------------------------------------------------------------
  // Instruction word fields
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] major;   // Bits 11:8
    logic [2:0] mid;     // Bits 7:5, bit position or {01,dest}
    logic [4:0] addr;    // Bits 4:0, register address
  } abse_instr_t;

  // Result written back to the register file
  typedef struct packed {
    logic       wr_en;
    logic [4:0] addr;
    logic [7:0] data;
  } abse_result_t;

  // Accumulator load from the rest of the core
  typedef struct packed {
    logic       en;
    logic [7:0] data;
  } abse_acc_load_t;

  // Instruction classes handled here
  typedef enum logic [1:0] {
    ABSE_NONE,
    ABSE_AND,
    ABSE_CLR,
    ABSE_SET
  } abse_class_t;

endpackage

// *** rtl/abse_exec.sv ***
`timescale 1ns/1ps
`include "abse_regs.svh"

module abse_exec (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 instr_valid,
  input  wire abse_pkg::abse_instr_t instr,
  input  wire logic [2:0][7:0]      port_pins,
  input  wire abse_pkg::abse_acc_load_t acc_load,
  output logic      [7:0]           accum,
  output logic                      zero_flag,
  output logic      [2:0][7:0]      port_latch,
  output abse_pkg::abse_result_t    result,
  output logic                      done
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]       rf [0:31];
  logic [2:0][7:0]  pins_meta;
  logic [2:0][7:0]  pins_sync;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  abse_pkg::abse_class_t cls;
  wire logic        hit_and;
  wire logic        hit_clr;
  wire logic        hit_set;
  wire logic        dest_reg;
  wire logic [2:0]  bit_pos;
  wire logic [4:0]  addr;
  wire logic        is_port;
  wire logic [1:0]  port_idx;
  wire logic [7:0]  pin_val;
  wire logic [7:0]  operand;
  wire logic [7:0]  mask;
  wire logic [7:0]  and_res;
  wire logic [7:0]  bit_res;
  wire logic        is_bit;
  wire logic        acc_take;

  // Opcode pattern match
  assign hit_and  = instr_valid && instr.major == `ABSE_OP_AND_HI
                    && instr.mid[2:1] == `ABSE_OP_AND_MID;
  assign hit_clr  = instr_valid && instr.major == `ABSE_OP_CLR;
  assign hit_set  = instr_valid && instr.major == `ABSE_OP_SET;
  assign cls      = hit_and ? abse_pkg::ABSE_AND :
                    hit_clr ? abse_pkg::ABSE_CLR :
                    hit_set ? abse_pkg::ABSE_SET : abse_pkg::ABSE_NONE;
  assign is_bit   = hit_clr || hit_set;

  // Core loads of the accumulator give way to the instructions taken here
  assign acc_take = acc_load.en && !hit_and && !is_bit;

  // Operand fields
  assign dest_reg = instr.mid[0];
  assign bit_pos  = instr.mid;
  assign addr     = instr.addr;

  // Port registers read their pins
  assign is_port  = addr >= `ABSE_PORT_LO && addr <= `ABSE_PORT_HI;
  assign port_idx = addr[1:0] - 2'h1;
  assign pin_val  = pins_sync[port_idx];
  assign operand  = is_port ? pin_val : rf[addr];

  // Datapath
  assign and_res  = accum & operand;
  assign mask     = 8'h01 << bit_pos;
  assign bit_res  = hit_set ? (operand | mask) : (operand & ~mask);

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    pins_meta <= port_pins;
    pins_sync <= pins_meta;
  end

  // ----------------------------------------------------------------
  // Accumulator and zero flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      accum     <= `ABSE_ACC_RST;
      zero_flag <= `ABSE_ZERO_RST;
    end
    else if (cls == abse_pkg::ABSE_AND)
    begin
      if (dest_reg == `ABSE_DEST_ACC)
        accum <= and_res;
      zero_flag <= (and_res == 8'h00);
    end
    else if (acc_take)
      accum <= acc_load.data;
  end

  // ----------------------------------------------------------------
  // Register file write
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 32; i++)
        rf[i] <= `ABSE_RF_RST;
    end
    else if (hit_and && dest_reg != `ABSE_DEST_ACC)
      rf[addr] <= and_res;
    else if (is_bit)
      rf[addr] <= bit_res;
  end

  // ----------------------------------------------------------------
  // Completion report
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      result <= '0;
      done   <= 1'h0;
    end
    else
    begin
      done         <= cls != abse_pkg::ABSE_NONE;
      result.wr_en <= is_bit || (hit_and && dest_reg != `ABSE_DEST_ACC);
      result.addr  <= addr;
      result.data  <= hit_and ? and_res : bit_res;
    end
  end

  // Output latches of the port registers
  assign port_latch = {rf[7], rf[6], rf[5]};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // AND into accumulator
  and_to_acc_a: assert property (hit_and && !dest_reg |=>
      accum == $past(and_res) && rf[$past(addr)] == $past(rf[addr]))
    else $error("AND to accumulator wrong");

  // AND into register
  and_to_reg_a: assert property (hit_and && dest_reg |=>
      rf[$past(addr)] == $past(and_res) && $stable(accum))
    else $error("AND to register wrong");

  // Zero flag follows the AND result
  zero_flag_a: assert property (hit_and |=>
      zero_flag == ($past(accum & operand) == 8'h00))
    else $error("Zero flag wrong");

  // One cycle completion of all three
  one_cycle_a: assert property ((hit_and || is_bit) |=> done)
    else $error("Completion not reported");

  // Nothing else reports completion
  done_pulse_a: assert property (!(hit_and || is_bit) |=> !done)
    else $error("Completion without instruction");

  // Refused words write nothing back
  no_write_a: assert property (!(hit_and || is_bit) |=> !result.wr_en)
    else $error("Write from refused word");

  // Accumulator moves only on AND to it or on a core load
  acc_hold_a: assert property (!(hit_and && !dest_reg) && !acc_take |=> $stable(accum))
    else $error("Accumulator changed unexpectedly");

  // Core load reaches the accumulator
  acc_load_a: assert property (acc_take |=> accum == $past(acc_load.data))
    else $error("Accumulator load lost");

  // Bit clear
  bit_clear_a: assert property (hit_clr |=>
      rf[$past(addr)] == ($past(operand) & ~(8'h01 << $past(instr.mid))))
    else $error("Bit clear wrong");

  // Bit set
  bit_set_a: assert property (hit_set |=>
      rf[$past(addr)] == ($past(operand) | (8'h01 << $past(instr.mid))))
    else $error("Bit set wrong");

  // Bit instructions leave the flags
  bit_flags_a: assert property (is_bit |=>
      $stable(zero_flag) && $stable(accum))
    else $error("Bit op touched flags");

  // Bit operand fields
  bit_fields_a: assert property (is_bit |=>
      result.wr_en && result.addr == $past(instr[4:0]))
    else $error("Bit op fields wrong");

  // Port reads use the pins two cycles late
  port_read_a: assert property (hit_and && is_port && dest_reg |=>
      result.data == ($past(accum) & $past(pins_sync[port_idx])))
    else $error("Port read not from pins");

  // Main scenarios
  cov_and_acc_c: cover property (hit_and && !dest_reg ##1 zero_flag);
  cov_and_reg_c: cover property (hit_and && dest_reg && is_port);
  cov_clr_set_c: cover property (hit_clr ##1 hit_set);
  cov_acc_load_c: cover property (acc_take ##2 hit_and);
  cov_and_nz_c:  cover property (hit_and ##1 !zero_flag);

endmodule

// *** verif/and_bit_set_clear_exec_tb_top.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module and_bit_set_clear_exec_tb_top;
  logic                   clk;
  logic                   nrst;
  logic                   instr_valid;
  abse_pkg::abse_instr_t  instr;
  logic [2:0][7:0]        port_pins;
  abse_pkg::abse_acc_load_t acc_load;
  logic [7:0]             accum;
  logic                   zero_flag;
  logic [2:0][7:0]        port_latch;
  abse_pkg::abse_result_t result;
  logic                   done;
  int                     error_cnt;
  int                     checks;
  int                     cyc;
  logic [7:0]             exp;

  abse_exec DUT (.clk(clk), .nrst(nrst), .instr_valid(instr_valid), .instr(instr), .port_pins(port_pins),
                 .acc_load(acc_load), .accum(accum), .zero_flag(zero_flag), .port_latch(port_latch),
                 .result(result), .done(done));

  // Clock and cycle ceiling
  initial clk = 1'b0;
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      final_report();
    end
  end

  // Compare and count
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] want);
    checks++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask

  // Issue one instruction; outputs are settled at the return
  task automatic run(input logic [11:0] op);
    @(negedge clk);
    instr       = op;
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
  endtask

  // Load the accumulator as the rest of the core would
  task automatic load_acc(input logic [7:0] val);
    @(negedge clk);
    acc_load = {1'h1, val};
    @(negedge clk);
    acc_load = '0;
  endtask

  // Set each bit, clear two, use the top address
  task automatic test_bits();
    exp = 8'h00;
    for (int b = 0; b < 8; b++)
    begin
      run({4'h5, 3'(b), 5'h03});
      exp[b] = 1'b1;
      check("set result", result, {1'b1, 5'h03, exp});
      check("set done", done, 1'b1);
    end
    run(12'h4E3);
    run(12'h403);
    check("clear result", result, {1'b1, 5'h03, 8'h7E});
    run(12'h5FF);
    check("top addr", result, {1'b1, 5'h1F, 8'h80});
    check("flag kept", zero_flag, 1'b0);
    $display("test_bits finished");
  endtask

  // AND into accumulator, then into the register
  task automatic test_and();
    load_acc(8'hC3);
    run(12'h143);
    check("and done", done, 1'h1);
    check("and accum", accum, 8'h42);
    check("and no write", result.wr_en, 1'h0);
    check("and zero", zero_flag, 1'h0);
    run(12'h5A3);
    check("reg kept", result, {1'h1, 5'h03, 8'h7E});
    check("flag kept", zero_flag, 1'h0);
    load_acc(8'h81);
    run(12'h163);
    check("and to reg", result, {1'h1, 5'h03, 8'h00});
    check("accum kept", accum, 8'h81);
    check("and zero 2", zero_flag, 1'h1);
    run(12'h523);
    check("reg cleared", result, {1'h1, 5'h03, 8'h02});
    check("flag kept 2", zero_flag, 1'h1);
    run(12'h143);
    check("and accum 2", accum, 8'h00);
    check("and zero 3", zero_flag, 1'h1);
    $display("test_and finished");
  endtask

  // Port register operands come from the pins
  task automatic test_port();
    run(12'h5E5);
    check("port set", result, {1'b1, 5'h05, 8'hBC});
    check("port latch", port_latch[0], 8'hBC);
    port_pins[0] = 8'h0F;
    repeat (3) @(negedge clk);
    run(12'h405);
    check("port clear", result, {1'b1, 5'h05, 8'h0E});
    check("port latch 2", port_latch[0], 8'h0E);
    run(12'h527);
    check("port 7 set", result, {1'h1, 5'h07, 8'hA2});
    check("port latches", port_latch, {8'hA2, 8'h00, 8'h0E});
    load_acc(8'h0D);
    run(12'h165);
    check("port and", result, {1'h1, 5'h05, 8'h0D});
    check("port and zero", zero_flag, 1'h0);
    $display("test_port finished");
  endtask

  // Foreign opcodes are ignored
  task automatic test_other();
    run(12'h600);
    check("other done", done, 1'b0);
    run(12'h1C3);
    check("add done", done, 1'b0);
    check("add result", result.wr_en, 1'b0);
    check("other accum", accum, 8'h0D);
    check("other zero", zero_flag, 1'h0);
    $display("test_other finished");
  endtask

  // Reset in mid-run clears the state
  task automatic test_reset();
    @(negedge clk);
    nrst = 1'h0;
    repeat (2) @(negedge clk);
    check("rst accum", accum, 8'h00);
    check("rst zero", zero_flag, 1'h0);
    check("rst latches", port_latch, 24'h000000);
    check("rst result", result, 14'h0000);
    check("rst done", done, 1'h0);
    nrst = 1'h1;
    run(12'h503);
    check("rst reg", result, {1'h1, 5'h03, 8'h01});
    $display("test_reset finished");
  endtask

  // Verdict
  task automatic final_report();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    nrst        = 1'b0;
    instr_valid = 1'b0;
    instr       = '0;
    acc_load    = '0;
    port_pins   = {8'hA0, 8'h00, 8'h3C};
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    test_bits();
    test_and();
    test_port();
    test_other();
    test_reset();
    final_report();
  end
endmodule
